// ==== hdl/probe_latch_regs.svh ====
// Register indices, field positions, reset values and bus constants of the probe latch
`ifndef PROBE_LATCH_REGS_SVH
`define PROBE_LATCH_REGS_SVH
`default_nettype none
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define POLARITY_IDX 16'h2007
`define CTRL_IDX 16'h60b8
`define STATUS_IDX 16'h60b9
`define CH1_RISE_POS_IDX 16'h60ba
`define CH1_FALL_POS_IDX 16'h60bb
`define CH2_RISE_POS_IDX 16'h60bc
`define CH2_FALL_POS_IDX 16'h60bd
`define CH1_RISE_CNT_IDX 16'h60d5
`define CH1_FALL_CNT_IDX 16'h60d6
`define CH2_RISE_CNT_IDX 16'h60d7
`define CH2_FALL_CNT_IDX 16'h60d8
`define DIN_LEVELS_IDX 16'h60fd
// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CH_FIELD_W 8
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_SOURCE_BIT 2
`define CTRL_RISE_BIT 4
`define CTRL_FALL_BIT 5
`define STAT_ENABLE_BIT 0
`define STAT_RISE_DONE_BIT 1
`define STAT_FALL_DONE_BIT 2
`define DIN_PROBE_ONE_BIT 26
`define DIN_PROBE_TWO_BIT 27
// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define CTRL_RESET 16'h0000
`define CTRL_WRITE_MASK 16'h3737
`define POLARITY_RESET 2'b11
`define SYNC_RESET 3'b000
`endif
`default_nettype wire

// ==== hdl/probe_latch_pkg.sv ====
// Types shared by the probe latch modules
`default_nettype none
package probe_latch_pkg;
   typedef struct packed {
      logic enable;
      logic continuous;
      logic use_index;
      logic rise_en;
      logic fall_en;
   } probe_cfg_t;
endpackage
`default_nettype wire

// ==== hdl/probe_channel_if.sv ====
// Configuration, trigger and results of one probe channel
`timescale 1ns/1ns
`default_nettype none
interface probe_channel_if #(
   parameter int POS_W = 32,
   parameter int CNT_W = 32
);
   import probe_latch_pkg::*;
   probe_cfg_t cfg;
   logic trig;
   logic [POS_W-1:0] position;
   logic [POS_W-1:0] rise_pos;
   logic [POS_W-1:0] fall_pos;
   logic [CNT_W-1:0] rise_cnt;
   logic [CNT_W-1:0] fall_cnt;
   logic rise_done;
   logic fall_done;
   modport ctrl (output cfg, trig, position,
                 input rise_pos, fall_pos, rise_cnt, fall_cnt, rise_done, fall_done);
   modport chan (input cfg, trig, position,
                 output rise_pos, fall_pos, rise_cnt, fall_cnt, rise_done, fall_done);
endinterface
`default_nettype wire

// ==== hdl/probe_channel.sv ====
// Edge capture, latch registers and counters of one probe channel
`timescale 1ns/1ns
`default_nettype none
module probe_channel
   import probe_latch_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int CNT_W = 32
) (
   input wire logic ref_clk,
   input wire logic resetn,
   probe_channel_if.chan pc
);
   // ----------------------------------------------------------------
   // Edge detection and arming
   // ----------------------------------------------------------------
   probe_cfg_t cfg_q;
   logic prev_q;
   logic armed_q;
   logic cfg_change;
   logic src_change;
   logic arm_now;
   logic live;
   logic rise_cap;
   logic fall_cap;
   assign cfg_change = (pc.cfg != cfg_q);
   // A source switch would fake an edge from the old trigger level
   assign src_change = (pc.cfg.use_index != cfg_q.use_index);
   assign arm_now = pc.cfg.enable & ((pc.cfg.enable & ~cfg_q.enable) | armed_q);
   assign live = pc.cfg.enable & (pc.cfg.continuous | arm_now);
   assign rise_cap = live & pc.cfg.rise_en & pc.trig & ~prev_q & ~src_change;
   assign fall_cap = live & pc.cfg.fall_en & ~pc.trig & prev_q & ~src_change;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= '0;
         prev_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         cfg_q <= pc.cfg;
         prev_q <= pc.trig;
         armed_q <= arm_now & ~(rise_cap | fall_cap);
      end
   end
   // ----------------------------------------------------------------
   // Latched positions, sampled in the cycle the edge is seen
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pc.rise_pos <= '0;
         pc.fall_pos <= '0;
      end else begin
         if (rise_cap) begin
            pc.rise_pos <= pc.position;
         end
         if (fall_cap) begin
            pc.fall_pos <= pc.position;
         end
      end
   end
   // ----------------------------------------------------------------
   // Counters and executed flags; a capture beats a config clear
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pc.rise_cnt <= '0;
         pc.fall_cnt <= '0;
         pc.rise_done <= 1'b0;
         pc.fall_done <= 1'b0;
      end else begin
         if (cfg_change) begin
            pc.rise_cnt <= {{(CNT_W-1){1'b0}}, rise_cap};
            pc.fall_cnt <= {{(CNT_W-1){1'b0}}, fall_cap};
         end else begin
            pc.rise_cnt <= pc.rise_cnt + {{(CNT_W-1){1'b0}}, rise_cap};
            pc.fall_cnt <= pc.fall_cnt + {{(CNT_W-1){1'b0}}, fall_cap};
         end
         pc.rise_done <= rise_cap | (pc.rise_done & ~cfg_change);
         pc.fall_done <= fall_cap | (pc.fall_done & ~cfg_change);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/dual_probe_position_latch.sv ====
// Two-channel probe position latch with an Avalon-MM register slave
`include "probe_latch_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Mode bit selects single or continuous
// - Bit 2 picks probe one or index
// - Bit 10 picks probe two or index
// - Bit 4 enables channel one rising capture
// - Bit 5 enables channel one falling capture
// - Bits 12, 13 enable channel two edges
// - Status bits 1, 2 flag channel one captures
// - Status bits 9, 10 flag channel two captures
// - Channel one latches position per edge
// - Channel two latches position per edge
// - Channel one counts rising and falling captures
// - Channel two counts rising and falling captures
// - Single shot takes only first trigger
// - Continuous mode keeps capturing, overwriting values
// - Status shows enables; reserved bits zero
// - Polarity setting inverts each probe input
// - Config change clears counters and status
// - Probe levels shown at bits 26, 27
module dual_probe_position_latch
   import probe_latch_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int CNT_W = 32,
   parameter int ADDR_W = 18
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic probe_input_one,
   input wire logic probe_input_two,
   input wire logic encoder_index,
   input wire logic [POS_W-1:0] feedback_position
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int NUM_CH = 2;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [1:0] probe_polarity_setting_q;
   logic [15:0] ctrl_q;
   logic ack_q;
   logic [31:0] rdata_d;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;
   logic [15:0] ctrl_d;
   logic [1:0] probe_polarity_setting_d;
   logic [15:0] word_idx;
   logic req;
   logic wr_done;
   logic [1:0] probe_level;
   logic [1:0] probe_logical;
   logic [31:0] digital_input_levels;
   logic [15:0] status_word;
   logic [POS_W-1:0] rise_pos [NUM_CH];
   logic [POS_W-1:0] fall_pos [NUM_CH];
   logic [CNT_W-1:0] rise_cnt [NUM_CH];
   logic [CNT_W-1:0] fall_cnt [NUM_CH];
   logic [NUM_CH-1:0] rise_done;
   logic [NUM_CH-1:0] fall_done;
   logic [NUM_CH-1:0] ch_enable;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Probe pins and the index pulse are asynchronous to ref_clk.
   // Capture is therefore two to three cycles behind the pin edge,
   // and the latched position is the one seen at detection time.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= `SYNC_RESET;
         sync2_q <= `SYNC_RESET;
      end else begin
         sync1_q <= {encoder_index, probe_input_two, probe_input_one};
         sync2_q <= sync1_q;
      end
   end

   assign probe_level = sync2_q[1:0];

   // ----------------------------------------------------------------
   // Polarity: a clear bit inverts its probe input
   // ----------------------------------------------------------------
   assign probe_logical = probe_level ^ ~probe_polarity_setting_q;

   // ----------------------------------------------------------------
   // Digital input object: live pin levels
   // ----------------------------------------------------------------
   always_comb begin
      digital_input_levels = 32'h0000_0000;
      digital_input_levels[`DIN_PROBE_ONE_BIT] = probe_level[0];
      digital_input_levels[`DIN_PROBE_TWO_BIT] = probe_level[1];
   end

   // ----------------------------------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------------------------------
   // Every access waits exactly one cycle; read data are registered
   // so the mux never sits in the readdata path.
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_done = avs_write & ack_q;
   assign word_idx = avs_address[17:2];
   assign avs_readdata = readdata_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // ----------------------------------------------------------------
   // Control word and polarity setting
   // ----------------------------------------------------------------
   // Reserved control bits are not stored and read back as zero.
   // Re-arming single shot relies on software writing enable low and
   // then high again; two separate writes give the channel an edge.
   // Lanes 2 and 3 carry no control bits and are ignored.
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_done && word_idx == `CTRL_IDX) begin
         if (avs_byteenable[0]) begin
            ctrl_d[7:0] = avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            ctrl_d[15:8] = avs_writedata[15:8];
         end
         ctrl_d = ctrl_d & `CTRL_WRITE_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= `CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // A polarity change while a channel is enabled looks like an edge
   always_comb begin
      probe_polarity_setting_d = probe_polarity_setting_q;
      if (wr_done && word_idx == `POLARITY_IDX && avs_byteenable[0]) begin
         probe_polarity_setting_d = avs_writedata[1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         probe_polarity_setting_q <= `POLARITY_RESET;
      end else begin
         probe_polarity_setting_q <= probe_polarity_setting_d;
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
         localparam int B = ch * `CH_FIELD_W;
         probe_channel_if #(.POS_W(POS_W), .CNT_W(CNT_W)) pc ();

         assign pc.cfg.enable = ctrl_q[B + `CTRL_ENABLE_BIT];
         assign pc.cfg.continuous = ctrl_q[B + `CTRL_MODE_BIT];
         assign pc.cfg.use_index = ctrl_q[B + `CTRL_SOURCE_BIT];
         assign pc.cfg.rise_en = ctrl_q[B + `CTRL_RISE_BIT];
         assign pc.cfg.fall_en = ctrl_q[B + `CTRL_FALL_BIT];
         // Index pulse is shared; each channel otherwise sees its own probe
         assign pc.trig = pc.cfg.use_index ? sync2_q[2] : probe_logical[ch];
         assign pc.position = feedback_position;

         probe_channel #(
            .POS_W(POS_W),
            .CNT_W(CNT_W)
         ) u_channel (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .pc(pc.chan)
         );

         assign rise_pos[ch] = pc.rise_pos;
         assign fall_pos[ch] = pc.fall_pos;
         assign rise_cnt[ch] = pc.rise_cnt;
         assign fall_cnt[ch] = pc.fall_cnt;
         assign rise_done[ch] = pc.rise_done;
         assign fall_done[ch] = pc.fall_done;
         assign ch_enable[ch] = pc.cfg.enable;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   always_comb begin
      status_word = 16'h0000;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         status_word[ch * `CH_FIELD_W + `STAT_ENABLE_BIT] = ch_enable[ch];
         status_word[ch * `CH_FIELD_W + `STAT_RISE_DONE_BIT] = rise_done[ch];
         status_word[ch * `CH_FIELD_W + `STAT_FALL_DONE_BIT] = fall_done[ch];
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Unmapped indices read zero and ignore writes, but are still
   // acknowledged so the master never hangs.
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (word_idx)
         `POLARITY_IDX: begin
            rdata_d[1:0] = probe_polarity_setting_q;
         end
         `CTRL_IDX: begin
            rdata_d[15:0] = ctrl_q;
         end
         `STATUS_IDX: begin
            rdata_d[15:0] = status_word;
         end
         `CH1_RISE_POS_IDX: begin
            rdata_d[POS_W-1:0] = rise_pos[0];
         end
         `CH1_FALL_POS_IDX: begin
            rdata_d[POS_W-1:0] = fall_pos[0];
         end
         `CH2_RISE_POS_IDX: begin
            rdata_d[POS_W-1:0] = rise_pos[1];
         end
         `CH2_FALL_POS_IDX: begin
            rdata_d[POS_W-1:0] = fall_pos[1];
         end
         `CH1_RISE_CNT_IDX: begin
            rdata_d[CNT_W-1:0] = rise_cnt[0];
         end
         `CH1_FALL_CNT_IDX: begin
            rdata_d[CNT_W-1:0] = fall_cnt[0];
         end
         `CH2_RISE_CNT_IDX: begin
            rdata_d[CNT_W-1:0] = rise_cnt[1];
         end
         `CH2_FALL_CNT_IDX: begin
            rdata_d[CNT_W-1:0] = fall_cnt[1];
         end
         `DIN_LEVELS_IDX: begin
            rdata_d = digital_input_levels;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // Loaded only in the waiting cycle so the data hold steady while
   // waitrequest is low.
   always_comb begin
      readdata_d = readdata_q;
      if (avs_read && !ack_q) begin
         readdata_d = rdata_d;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         readdata_q <= 32'h0000_0000;
      end else begin
         readdata_q <= readdata_d;
      end
   end
endmodule
`default_nettype wire

// ==== verification/dual_probe_latch_props.sv ====
// Bus-side properties of the dual probe position latch
`include "probe_latch_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module dual_probe_latch_props
   import probe_latch_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int ADDR_W = 18
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic probe_input_one,
   input wire logic probe_input_two,
   input wire logic encoder_index,
   input wire logic [POS_W-1:0] feedback_position
);
   logic [15:0] idx;
   logic rd_done;
   logic wr_done;
   logic [15:0] ctrl_q;
   logic [1:0] pol_q;
   assign idx = avs_address[17:2];
   assign rd_done = avs_read && !avs_waitrequest;
   assign wr_done = avs_write && !avs_waitrequest;
   // ------------------------------------------------
   // Shadow of the writable registers
   // ------------------------------------------------
   // Full-word writes only: the bench never drives partial lanes
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= 16'h0000;
         pol_q <= 2'b11;
      end else if (wr_done && idx == `CTRL_IDX) begin
         ctrl_q <= avs_writedata[15:0] & `CTRL_WRITE_MASK;
      end else if (wr_done && idx == `POLARITY_IDX) begin
         pol_q <= avs_writedata[1:0];
      end
   end
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_one_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus answer late");
   property p_idle_free;
      !(avs_read || avs_write) |-> !avs_waitrequest;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("wait while idle");
   property p_stat_rsv;
      rd_done && idx == `STATUS_IDX |-> (avs_readdata & 32'hfffff8f8) == 32'h0;
   endproperty
   a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved set");
   property p_stat_en;
      rd_done && idx == `STATUS_IDX |-> {avs_readdata[8], avs_readdata[0]} == {ctrl_q[8], ctrl_q[0]};
   endproperty
   a_stat_en: assert property (p_stat_en) else $error("status enable wrong");
   property p_done_en;
      rd_done && idx == `STATUS_IDX |-> (avs_readdata[0] || avs_readdata[2:1] == 2'b00)
         && (avs_readdata[8] || avs_readdata[10:9] == 2'b00);
   endproperty
   a_done_en: assert property (p_done_en) else $error("flag on idle channel");
   property p_ctrl_back;
      rd_done && idx == `CTRL_IDX |-> avs_readdata == {16'h0000, ctrl_q};
   endproperty
   a_ctrl_back: assert property (p_ctrl_back) else $error("control readback");
   property p_pol_back;
      rd_done && idx == `POLARITY_IDX |-> avs_readdata[1:0] == pol_q;
   endproperty
   a_pol_back: assert property (p_pol_back) else $error("polarity readback");
   property p_unmapped;
      rd_done && idx == 16'h0000 |-> avs_readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind dual_probe_position_latch dual_probe_latch_props #(.POS_W(POS_W), .ADDR_W(ADDR_W)) i_props (
   .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .probe_input_one, .probe_input_two, .encoder_index,
   .feedback_position);
`default_nettype wire

// ==== verification/probe_sensor_model.sv ====
// Probe sensors, encoder index and moving position at the trigger pins
`timescale 1ns/1ns
`default_nettype none
module probe_sensor_model #(
   parameter int POS_W = 32
) (
   input wire logic ref_clk,
   output logic probe_input_one,
   output logic probe_input_two,
   output logic encoder_index,
   output logic [POS_W-1:0] feedback_position
);
   initial begin
      probe_input_one = 1'b0;
      probe_input_two = 1'b0;
      encoder_index = 1'b0;
      feedback_position = '0;
   end
   // Position is held through the capture window, then moves away so a stale latch shows
   task automatic move(input int pin, input logic lvl, input logic [POS_W-1:0] pos);
      @(posedge ref_clk);
      case (pin)
         0: probe_input_one <= lvl;
         1: probe_input_two <= lvl;
         default: encoder_index <= lvl;
      endcase
      feedback_position <= pos;
      repeat (8) @(posedge ref_clk);
      feedback_position <= ~pos;
   endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the dual probe position latch
`include "probe_latch_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   import probe_latch_pkg::*;
   logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [17:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, feedback_position;
   logic [3:0] avs_byteenable;
   logic probe_input_one, probe_input_two, encoder_index;
   int num_errors, n_tests;
   integer seed;
   logic [15:0] ctrl;
   logic [1:0] pol, armed;
   logic [2:0] lvl;
   logic [3:0] done;
   logic [31:0] cnt [4];
   logic [31:0] lat [4];
   dual_probe_position_latch i_dual_probe_position_latch (.ref_clk, .resetn, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .probe_input_one, .probe_input_two, .encoder_index, .feedback_position);
   probe_sensor_model i_probe_sensor_model (.ref_clk, .probe_input_one, .probe_input_two,
      .encoder_index, .feedback_position);
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ------------------------------------------------
   // Bus, compare and expectation tasks
   // ------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         $display("[FAIL] %0t bus answer timed out", $time);
         test_done;
      end
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, idx, 32'h0, d);
      chk(d, exp);
   endtask
   // Config change of a channel clears its counters and flags; enable rise arms it
   task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      logic [15:0] nc;
      bus(1'b1, idx, wd, d);
      if (idx == `POLARITY_IDX) pol = wd[1:0];
      if (idx == `CTRL_IDX) begin
         nc = wd[15:0] & `CTRL_WRITE_MASK;
         for (int c = 0; c < 2; c++) begin
            if (nc[c*8+:8] != ctrl[c*8+:8]) begin
               cnt[2*c] = 32'h0;
               cnt[2*c+1] = 32'h0;
               done[2*c+:2] = 2'b00;
            end
            if (nc[c*8] && !ctrl[c*8]) armed[c] = 1'b1;
         end
         ctrl = nc;
      end
   endtask
   function automatic logic eff(input int c, input logic [2:0] lv);
      return ctrl[c*8+2] ? lv[2] : (pol[c] ? lv[c] : ~lv[c]);
   endfunction
   task automatic ev(input int p, input logic v);
      logic [31:0] pos;
      logic [2:0] nl;
      int k;
      pos = $random(seed);
      nl = lvl;
      nl[p] = v;
      for (int c = 0; c < 2; c++) begin
         k = 2 * c + (eff(c, nl) ? 0 : 1);
         if (ctrl[c*8] && eff(c, nl) != eff(c, lvl) && ctrl[c*8+4+k%2]
             && (ctrl[c*8+1] || armed[c])) begin
            cnt[k]++;
            lat[k] = pos;
            done[k] = 1'b1;
            if (!ctrl[c*8+1]) armed[c] = 1'b0;
         end
      end
      lvl = nl;
      i_probe_sensor_model.move(p, v, pos);
   endtask
   task automatic chk_all;
      rd_chk(`STATUS_IDX, {21'h0, done[3:2], ctrl[8], 5'h0, done[1:0], ctrl[0]});
      for (int k = 0; k < 4; k++) begin
         rd_chk(16'(`CH1_RISE_POS_IDX + k), lat[k]);
         rd_chk(16'(`CH1_RISE_CNT_IDX + k), cnt[k]);
      end
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [15:0] modes [3];
      seed = 32'hf6ee43c3;
      modes = '{16'h3333, 16'h2313, 16'h1323};
      {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      {ctrl, armed, lvl, done, num_errors, n_tests} = '0;
      pol = 2'b11;
      for (int k = 0; k < 4; k++) {cnt[k], lat[k]} = '0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_chk(`CTRL_IDX, 32'h0);
      rd_chk(`POLARITY_IDX, 32'h3);
      chk_all;
      wr(16'h0000, 32'hffffffff);
      rd_chk(16'h0000, 32'h0);
      wr(`CH1_RISE_CNT_IDX, 32'h5);
      wr(`CTRL_IDX, 32'hffffffff);
      rd_chk(`CTRL_IDX, 32'h3737);
      chk_all;
      // Continuous both edges, then one edge per channel, random pin traffic
      foreach (modes[i]) begin
         wr(`CTRL_IDX, {16'h0000, modes[i]});
         repeat (8) begin
            int p;
            p = $unsigned($random(seed)) % 2;
            ev(p, ~lvl[p]);
         end
         chk_all;
      end
      // Inverted probe one: polarity changed only while disabled
      wr(`CTRL_IDX, 32'h0);
      wr(`POLARITY_IDX, 32'h2);
      wr(`CTRL_IDX, 32'h0013);
      repeat (3) ev(0, ~lvl[0]);
      chk_all;
      bus(1'b0, `DIN_LEVELS_IDX, 32'h0, d);
      chk({30'h0, d[27:26]}, {30'h0, lvl[1:0]});
      wr(`CTRL_IDX, 32'h0);
      wr(`POLARITY_IDX, 32'h3);
      // Index source: channel one continuous, channel two single shot, re-armed
      wr(`CTRL_IDX, 32'h3537);
      repeat (2) begin
         repeat (3) begin
            ev(2, 1'b1);
            ev(2, 1'b0);
         end
         chk_all;
         wr(`CTRL_IDX, 32'h3437);
         wr(`CTRL_IDX, 32'h3537);
      end
      chk_all;
      test_done;
   end
   // Whole run is well under a thousand cycles; this allows ample margin
   initial begin
      #400000;
      num_errors++;
      test_done;
   end
endmodule
`default_nettype wire
